//--- design/rcr_pkg.sv
package rcr_pkg;
    localparam logic [7:0] OFS_LANE_B_DEEMPH   = 8'h18;
    localparam logic [7:0] OFS_LANE_B_IDLE_TH  = 8'h19;
    localparam logic [7:0] OFS_RESERVED_CFG    = 8'h23;
    localparam logic [7:0] OFS_LANE_A_SWING    = 8'h25;
    localparam logic [7:0] OFS_IDLE_DETECT     = 8'h28;
    localparam logic [7:0] OFS_LANE_B_SWING    = 8'h2D;
    localparam logic [7:0] OFS_DEVICE_INFO     = 8'h51;

    localparam logic [7:0] RST_LANE_B_DEEMPH   = 8'h82;
    localparam logic [7:0] RST_LANE_B_IDLE_TH  = 8'h00;
    localparam logic [7:0] RST_RESERVED_CFG    = 8'h00;
    localparam logic [7:0] RST_SWING           = 8'hAD;
    localparam logic [7:0] RST_IDLE_DETECT     = 8'h00;

    // Bits 7:5 of the de-emphasis register are read-only
    localparam logic [7:0] DEEMPH_WR_MASK      = 8'h1F;

    localparam int         DEEMPH_LSB          = 0;
    localparam int         SLOW_OUT_OF_BAND_DETECT_BIT        = 7;
    localparam int         ASSERT_TH_LSB       = 2;
    localparam int         DEASSERT_TH_LSB     = 0;
    localparam int         SWING_LSB           = 2;
    localparam int         FAST_IDLE_OVR_BIT   = 6;
    localparam int         RAISED_TH_LSB       = 4;
    localparam int         FAST_IDLE_EN_LSB    = 2;
    localparam int         REV_LSB             = 5;

    localparam logic [2:0] DEEMPH_RST_CODE     = 3'h2;
    localparam logic [1:0] ASSERT_TH_RST_CODE  = 2'h0;
    localparam logic [1:0] DEASSERT_TH_RST_CODE = 2'h0;
    localparam logic [2:0] SWING_RST_CODE      = 3'h3;
    localparam logic [3:0] BITS_PER_BYTE       = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ADDR  = 4'h1,
        ST_AACK  = 4'h3,
        ST_REG   = 4'h2,
        ST_RACK  = 4'h6,
        ST_WDAT  = 4'h7,
        ST_WACK  = 4'h5,
        ST_RDAT  = 4'h4,
        ST_MACK  = 4'hC
    } rcr_state_t;
endpackage

//--- design/rcr_regs.sv
`timescale 1ns/1ns
// Functional notes
// - Lane B de-emphasis code 000..111 gives 0 to -12 dB; reset -3.5 dB code.
// - Lane B idle threshold bit 7 enables slow out-of-band detect; register resets zero.
// - Assert threshold bits 3:2, reset 180 mV code, used only when override input set.
// - Deassert threshold bits 1:0, reset 110 mV code, same override condition applies.
// - Lane A swing bits 4:2 give 700..1300 mV; reset code gives 1000 mV.
// - Lane B swing same encoding in own register resetting to 0xAD.
// - Idle control bits 5 and 4 raise detect thresholds for lanes A, B; reset zero.
module rcr_regs #(
    parameter logic [6:0] SLAVE_ADDR = 7'h5A,
    parameter logic [2:0] REVISION   = 3'h2,  // Arbitrary value
    parameter logic [4:0] PART_CODE  = 5'h11  // Arbitrary value
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       smb_scl_i,
    input  wire logic       smb_sda_i,
    output logic            smb_sda_o,
    output logic            smb_sda_oe_o,
    input  wire logic       idle_override_i,
    output logic [2:0]      deemph_level_o,
    output logic            slow_out_of_band_detect_o,
    output logic [1:0]      idle_assert_threshold_o,
    output logic [1:0]      idle_deassert_threshold_o,
    output logic [2:0]      lane_a_swing_level_o,
    output logic [2:0]      lane_b_swing_level_o,
    output logic            fast_idle_override_o,
    output logic [1:0]      raised_detect_threshold_sel_o,
    output logic [1:0]      fast_idle_en_o
);
    import rcr_pkg::*;

    rcr_state_t state_r;
    logic [7:0] deemph_r;
    logic [7:0] idle_th_r;
    logic [7:0] rsvd_r;
    logic [7:0] swing_a_r;
    logic [7:0] idle_ctl_r;
    logic [7:0] swing_b_r;
    logic [1:0] eff_assert_r;
    logic [1:0] eff_deassert_r;
    logic       scl_q_r;
    logic       sda_q_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic       rw_r;
    logic       nack_r;
    logic       sda_oe_r;
    logic       sda_o_r;
    logic [7:0] rd_data;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       byte_done;
    logic       wr_stb;

    assign scl_rise   = smb_scl_i && !scl_q_r;
    assign scl_fall   = !smb_scl_i && scl_q_r;
    assign start_cond = smb_scl_i && scl_q_r && sda_q_r && !smb_sda_i;
    assign stop_cond  = smb_scl_i && scl_q_r && !sda_q_r && smb_sda_i;
    assign byte_done  = (bit_cnt_r == BITS_PER_BYTE);
    assign wr_stb     = scl_fall && (state_r == ST_WDAT) && byte_done;

    always_comb
    begin
        if (ptr_r == OFS_LANE_B_DEEMPH)
            rd_data = deemph_r;
        else if (ptr_r == OFS_LANE_B_IDLE_TH)
            rd_data = idle_th_r;
        else if (ptr_r == OFS_RESERVED_CFG)
            rd_data = rsvd_r;
        else if (ptr_r == OFS_LANE_A_SWING)
            rd_data = swing_a_r;
        else if (ptr_r == OFS_IDLE_DETECT)
            rd_data = idle_ctl_r;
        else if (ptr_r == OFS_LANE_B_SWING)
            rd_data = swing_b_r;
        else if (ptr_r == OFS_DEVICE_INFO)
            rd_data = {REVISION, PART_CODE};
        else
            rd_data = 8'h00;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= smb_scl_i;
            sda_q_r <= smb_sda_i;
        end
    end

    // Bus protocol engine; data changes only while the clock line is low
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            rw_r      <= 1'b0;
            nack_r    <= 1'b0;
            sda_oe_r  <= 1'b0;
            sda_o_r   <= 1'b0;
        end
        else if (start_cond)
        begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end
        else if (stop_cond)
        begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state_r)
                ST_ADDR, ST_REG, ST_WDAT:
                begin
                    shift_r   <= {shift_r[6:0], smb_sda_i};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                ST_RDAT:
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                ST_MACK:
                    nack_r <= smb_sda_i;
                default:
                    bit_cnt_r <= bit_cnt_r;
            endcase
        end
        else if (scl_fall)
        begin
            case (state_r)
                ST_ADDR:
                    if (byte_done)
                    begin
                        // Other addresses are ignored until the next start
                        if (shift_r[7:1] == SLAVE_ADDR)
                        begin
                            state_r  <= ST_AACK;
                            rw_r     <= shift_r[0];
                            sda_oe_r <= 1'b1;
                        end
                        else
                            state_r <= ST_IDLE;
                    end
                ST_AACK:
                begin
                    bit_cnt_r <= 4'h0;
                    if (rw_r)
                    begin
                        state_r  <= ST_RDAT;
                        shift_r  <= rd_data;
                        sda_oe_r <= !rd_data[7];
                    end
                    else
                    begin
                        state_r  <= ST_REG;
                        sda_oe_r <= 1'b0;
                    end
                end
                ST_REG:
                    if (byte_done)
                    begin
                        ptr_r    <= shift_r;
                        state_r  <= ST_RACK;
                        sda_oe_r <= 1'b1;
                    end
                ST_RACK, ST_WACK:
                begin
                    state_r   <= ST_WDAT;
                    bit_cnt_r <= 4'h0;
                    sda_oe_r  <= 1'b0;
                end
                ST_WDAT:
                    if (byte_done)
                    begin
                        ptr_r    <= ptr_r + 8'h01;
                        state_r  <= ST_WACK;
                        sda_oe_r <= 1'b1;
                    end
                ST_RDAT:
                    if (byte_done)
                    begin
                        ptr_r    <= ptr_r + 8'h01;
                        state_r  <= ST_MACK;
                        sda_oe_r <= 1'b0;
                    end
                    else
                    begin
                        shift_r  <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= !shift_r[6];
                    end
                ST_MACK:
                begin
                    bit_cnt_r <= 4'h0;
                    if (nack_r)
                        state_r <= ST_IDLE;
                    else
                    begin
                        state_r  <= ST_RDAT;
                        shift_r  <= rd_data;
                        sda_oe_r <= !rd_data[7];
                    end
                end
                default:
                    state_r <= state_r;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            deemph_r   <= RST_LANE_B_DEEMPH;
            idle_th_r  <= RST_LANE_B_IDLE_TH;
            rsvd_r     <= RST_RESERVED_CFG;
            swing_a_r  <= RST_SWING;
            idle_ctl_r <= RST_IDLE_DETECT;
            swing_b_r  <= RST_SWING;
        end
        else if (wr_stb)
        begin
            if (ptr_r == OFS_LANE_B_DEEMPH)
                deemph_r <= (deemph_r & ~DEEMPH_WR_MASK) | (shift_r & DEEMPH_WR_MASK);
            else if (ptr_r == OFS_LANE_B_IDLE_TH)
                idle_th_r <= shift_r;
            else if (ptr_r == OFS_RESERVED_CFG)
                rsvd_r <= shift_r;
            else if (ptr_r == OFS_LANE_A_SWING)
                swing_a_r <= shift_r;
            else if (ptr_r == OFS_IDLE_DETECT)
                idle_ctl_r <= shift_r;
            else if (ptr_r == OFS_LANE_B_SWING)
                swing_b_r <= shift_r;
        end
    end

    // Without the override the analog side keeps its default thresholds
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            eff_assert_r   <= ASSERT_TH_RST_CODE;
            eff_deassert_r <= DEASSERT_TH_RST_CODE;
        end
        else
        begin
            eff_assert_r   <= idle_override_i ? idle_th_r[ASSERT_TH_LSB +: 2]
                                              : ASSERT_TH_RST_CODE;
            eff_deassert_r <= idle_override_i ? idle_th_r[DEASSERT_TH_LSB +: 2]
                                              : DEASSERT_TH_RST_CODE;
        end
    end

    assign smb_sda_o                     = sda_o_r;
    assign smb_sda_oe_o                  = sda_oe_r;
    assign deemph_level_o                = deemph_r[DEEMPH_LSB +: 3];
    assign slow_out_of_band_detect_o     = idle_th_r[SLOW_OUT_OF_BAND_DETECT_BIT];
    assign idle_assert_threshold_o       = eff_assert_r;
    assign idle_deassert_threshold_o     = eff_deassert_r;
    assign lane_a_swing_level_o          = swing_a_r[SWING_LSB +: 3];
    assign lane_b_swing_level_o          = swing_b_r[SWING_LSB +: 3];
    assign fast_idle_override_o          = idle_ctl_r[FAST_IDLE_OVR_BIT];
    assign raised_detect_threshold_sel_o = idle_ctl_r[RAISED_TH_LSB +: 2];
    assign fast_idle_en_o                = idle_ctl_r[FAST_IDLE_EN_LSB +: 2];

    AST_DEEMPH_RESET: assert property (@(posedge sys_clk_i) $past(rst_i) |-> deemph_level_o == DEEMPH_RST_CODE) else $error("deemph reset code wrong");
    AST_DEEMPH_TOP_RO: assert property (@(posedge sys_clk_i) disable iff (rst_i) deemph_r[7:5] == RST_LANE_B_DEEMPH[7:5]) else $error("deemph read-only bits changed");
    AST_SLOW_OUT_OF_BAND_DETECT_RESET: assert property (@(posedge sys_clk_i) $past(rst_i) |-> !slow_out_of_band_detect_o && idle_th_r == 8'h00) else $error("idle threshold reset wrong");
    AST_ASSERT_TH_GATE: assert property (@(posedge sys_clk_i) disable iff (rst_i) !idle_override_i ##1 !$past(rst_i) |-> idle_assert_threshold_o == ASSERT_TH_RST_CODE) else $error("assert threshold not gated");
    AST_DEASSERT_TH_PASS: assert property (@(posedge sys_clk_i) disable iff (rst_i) idle_override_i ##1 !$past(rst_i) |-> idle_deassert_threshold_o == $past(idle_th_r[1:0])) else $error("deassert threshold not applied");
    AST_SWING_A_RESET: assert property (@(posedge sys_clk_i) $past(rst_i) |-> lane_a_swing_level_o == SWING_RST_CODE) else $error("lane a swing reset wrong");
    AST_SWING_B_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i) wr_stb && ptr_r == OFS_LANE_B_SWING |=> swing_b_r == $past(shift_r)) else $error("lane b swing write lost");
    AST_RAISED_TH_RESET: assert property (@(posedge sys_clk_i) $past(rst_i) |-> raised_detect_threshold_sel_o == 2'h0) else $error("raised threshold reset wrong");
    AST_INFO_READ_ONLY: assert property (@(posedge sys_clk_i) disable iff (rst_i) wr_stb && ptr_r == OFS_DEVICE_INFO |=> $stable({deemph_r, idle_th_r, rsvd_r, swing_a_r, idle_ctl_r, swing_b_r})) else $error("device info write had an effect");

    COV_ADDR_ACK: cover property (@(posedge sys_clk_i) disable iff (rst_i) state_r == ST_AACK);
    COV_REG_WRITE: cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_stb);
    COV_READ_BYTE: cover property (@(posedge sys_clk_i) disable iff (rst_i) state_r == ST_MACK);
    COV_OVERRIDE: cover property (@(posedge sys_clk_i) disable iff (rst_i) idle_override_i && idle_th_r[3:2] != 2'h0);
endmodule

//--- tb/rcr_smb_host.sv
`timescale 1ns/1ns
module rcr_smb_host #(
    parameter logic [6:0] ADDR = 7'h5A
) (
    input  wire logic       clk_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_drv_o,
    output logic [7:0]      rd_data_o,
    output logic            rd_valid_o,
    output logic            ack_o
);
    // sda_drv_o high pulls the wire low; released SDA floats to the pull-up
    initial
    begin
        scl_o      = 1'b1;
        sda_drv_o  = 1'b0;
        rd_data_o  = 8'h00;
        rd_valid_o = 1'b0;
        ack_o      = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // SDA moves one clock after SCL falls, so it never changes while SCL is high
    task automatic bit_io(input logic b, output logic s);
        wt(1);
        sda_drv_o = ~b;
        wt(3);
        scl_o = 1'b1;
        wt(4);
        s = sda_i;
        scl_o = 1'b0;
    endtask
    // Serves as both START and repeated START
    task automatic start();
        wt(1);
        sda_drv_o = 1'b0;
        wt(3);
        scl_o = 1'b1;
        wt(4);
        sda_drv_o = 1'b1;
        wt(4);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        wt(1);
        sda_drv_o = 1'b1;
        wt(3);
        scl_o = 1'b1;
        wt(4);
        sda_drv_o = 1'b0;
        wt(4);
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d);
        logic k;
        start();
        tx({a, 1'b0}, k);
        ack_o = k;
        tx(ofs, k);
        tx(d, k);
        stop();
    endtask
    task automatic rd(input logic [7:0] ofs);
        logic       k;
        logic [7:0] d;
        start();
        tx({ADDR, 1'b0}, k);
        tx(ofs, k);
        start();
        tx({ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, k);
        stop();
        rd_data_o  = d;
        rd_valid_o = 1'b1;
        wt(1);
        rd_valid_o = 1'b0;
    endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    import rcr_pkg::*;
    localparam logic [2:0] REV  = 3'h5;   // Arbitrary value
    localparam logic [4:0] PART = 5'h0A;  // Arbitrary value
    localparam logic [7:0] OFS [8] = '{OFS_LANE_B_DEEMPH, OFS_LANE_B_IDLE_TH, OFS_RESERVED_CFG,
        OFS_LANE_A_SWING, OFS_IDLE_DETECT, OFS_LANE_B_SWING, OFS_DEVICE_INFO, 8'h30};
    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic       ovr       = 1'b0;
    logic       scl, drv, sda_o, sda_oe, rd_valid, ack, slow, fio;
    logic [7:0] rd_data, d, m18, m19, m23, m25, m28, m2d;
    logic [2:0] deemph, swa, swb;
    logic [1:0] ath, dth, rsel, fen;
    logic [7:0] exp_q [$];
    int         n_errors = 0;
    int         checks   = 0;
    int         seed_dummy;
    wire        sda_w = (drv || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
    always #10 sys_clk_i = ~sys_clk_i;
    rcr_regs #(.REVISION(REV), .PART_CODE(PART)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .smb_scl_i(scl), .smb_sda_i(sda_w),
        .smb_sda_o(sda_o), .smb_sda_oe_o(sda_oe), .idle_override_i(ovr),
        .deemph_level_o(deemph), .slow_out_of_band_detect_o(slow),
        .idle_assert_threshold_o(ath), .idle_deassert_threshold_o(dth),
        .lane_a_swing_level_o(swa), .lane_b_swing_level_o(swb),
        .fast_idle_override_o(fio), .raised_detect_threshold_sel_o(rsel),
        .fast_idle_en_o(fen));
    rcr_smb_host #(.ADDR(7'h5A)) host_u (
        .clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_drv_o(drv),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .ack_o(ack));
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge sys_clk_i)
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                n_errors++;
            else
                chk({11'h0, rd_data}, {11'h0, exp_q.pop_front()});
        end
    function automatic logic [7:0] exp_of(input logic [7:0] o);
        case (o)
            OFS_LANE_B_DEEMPH:  return m18;
            OFS_LANE_B_IDLE_TH: return m19;
            OFS_RESERVED_CFG:   return m23;
            OFS_LANE_A_SWING:   return m25;
            OFS_IDLE_DETECT:    return m28;
            OFS_LANE_B_SWING:   return m2d;
            OFS_DEVICE_INFO:    return {REV, PART};
            default:            return 8'h00;
        endcase
    endfunction
    task automatic upd(input logic [7:0] o, input logic [7:0] v);
        case (o)
            OFS_LANE_B_DEEMPH:  m18 = {3'b100, v[4:0]};
            OFS_LANE_B_IDLE_TH: m19 = v;
            OFS_RESERVED_CFG:   m23 = v;
            OFS_LANE_A_SWING:   m25 = v;
            OFS_IDLE_DETECT:    m28 = v;
            OFS_LANE_B_SWING:   m2d = v;
            default:            ;
        endcase
    endtask
    task automatic set_rst();
        m18 = 8'h82;
        m19 = 8'h00;
        m23 = 8'h00;
        m25 = 8'hAD;
        m28 = 8'h00;
        m2d = 8'hAD;
    endtask
    task automatic chk_ports();
        chk({deemph, slow, ath, dth, swa, swb, fio, rsel, fen},
            {m18[2:0], m19[7], ovr ? m19[3:2] : 2'h0, ovr ? m19[1:0] : 2'h0,
             m25[4:2], m2d[4:2], m28[6], m28[5:4], m28[3:2]});
    endtask
    task automatic rd(input logic [7:0] o);
        exp_q.push_back(exp_of(o));
        host_u.rd(o);
    endtask
    task automatic rd_all();
        for (int i = 0; i < 8; i++) rd(OFS[i]);
    endtask
    initial
    begin
        #1000000;
        n_errors++;
        conclude();
    end
    initial
    begin
        seed_dummy = $urandom(82954);
        set_rst();
        repeat (8) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        chk_ports();
        rd_all();
        for (int i = 0; i < 8; i++)
        begin
            d = $urandom;
            host_u.wr(7'h5A, OFS[i], d);
            upd(OFS[i], d);
        end
        rd_all();
        for (int k = 0; k < 8; k++)
        begin
            for (int i = 0; i < 6; i++)
            begin
                d = $urandom;
                d[2:0] = 3'(k);
                d[4:2] = (k == 7) ? 3'h6 : 3'(k);
                host_u.wr(7'h5A, OFS[i], d);
                upd(OFS[i], d);
            end
            ovr = k[0];
            repeat (2) @(negedge sys_clk_i);
            chk_ports();
        end
        host_u.wr(7'h3C, OFS_LANE_A_SWING, ~m25);
        chk({18'h0, ack}, 19'h0);
        rd(OFS_LANE_A_SWING);
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        set_rst();
        @(negedge sys_clk_i);
        chk_ports();
        rd_all();
        repeat (4) @(negedge sys_clk_i);
        conclude();
    end
endmodule
